// [rtl/irqos_defs.svh]
// offsets, field positions, reset values and timing counts of the interrupt output block
`ifndef IRQOS_DEFS_SVH
`define IRQOS_DEFS_SVH

// register byte addresses
`define IRQOS_OFF_CFG        12'h054
`define IRQOS_OFF_STS        12'h058
`define IRQOS_OFF_EN         12'h05C

// pin configuration fields
`define IRQOS_CFG_DEAS_MSB   31
`define IRQOS_CFG_DEAS_LSB   24
`define IRQOS_CFG_DEAS_CLR   14
`define IRQOS_CFG_DEAS_STS   13
`define IRQOS_CFG_IRQ_INT    12
`define IRQOS_CFG_IRQ_EN     8
`define IRQOS_CFG_POL        4
`define IRQOS_CFG_CLK_SEL    1
`define IRQOS_CFG_TYPE       0

// status and enable bit positions
`define IRQOS_B_SW           31
`define IRQOS_B_READY        30
`define IRQOS_B_TSU          29
`define IRQOS_B_FABRIC       28
`define IRQOS_B_PHY_B        27
`define IRQOS_B_PHY_A        26
`define IRQOS_B_TIMER        19
`define IRQOS_B_POWER        17
`define IRQOS_B_GPIO         12

// implemented bits of status and enable
`define IRQOS_STS_MASK       32'hFC0A_1000

// reset values
`define IRQOS_DEAS_RST       8'h00
`define IRQOS_EN_RST         32'h0000_0000
`define IRQOS_BIT_RST        1'b0

// hold-off step and clock period
`define IRQOS_DEAS_STEP_NS   10000
`define IRQOS_PCLK_NS        5
`define IRQOS_DEAS_STEP_CYC  (`IRQOS_DEAS_STEP_NS / `IRQOS_PCLK_NS)

`endif

// [rtl/irqos_pkg.sv]
// types shared by the interrupt output block
package irqos_pkg;

    // register selected by an apb address
    typedef enum logic [1:0] {
        IRQOS_SEL_CFG,
        IRQOS_SEL_STS,
        IRQOS_SEL_EN,
        IRQOS_SEL_NONE
    } irqos_sel_t;

    // hold-off sequencer states
    typedef enum logic {
        IRQOS_HOLD_IDLE,
        IRQOS_HOLD_RUN
    } irqos_hold_t;

endpackage

// [rtl/irqos_holdoff.sv]
// de-assertion hold-off timer of the interrupt output
`timescale 1ns/1ps
`include "irqos_defs.svh"

module irqos_holdoff #(
    parameter int unsigned STEP_CYC = `IRQOS_DEAS_STEP_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       soft_rst,
    input  wire logic [7:0] interval,
    input  wire logic       restart,
    input  wire logic       line,
    output logic            active
);
    import irqos_pkg::*;

    typedef struct packed {
        irqos_hold_t  state;
        logic [19:0]  cyc;
        logic [7:0]   steps;
        logic         line_d;
    } irqos_hold_st_t;

    irqos_hold_st_t st_r;
    irqos_hold_st_t st_nxt;

    // sequencer: a falling line while idle, or a clear request, starts a fresh interval
    always_comb begin
        st_nxt        = st_r;
        st_nxt.line_d = line;
        case (st_r.state)
            IRQOS_HOLD_IDLE: begin
                if ((restart || (st_r.line_d && !line)) && interval != `IRQOS_DEAS_RST) begin
                    st_nxt.state = IRQOS_HOLD_RUN;
                    st_nxt.cyc   = 20'd0;
                    st_nxt.steps = 8'd1;
                end
            end
            IRQOS_HOLD_RUN: begin
                if (restart) begin
                    st_nxt.cyc   = 20'd0;
                    st_nxt.steps = 8'd1;
                end else if (st_r.cyc == 20'(STEP_CYC - 1)) begin
                    st_nxt.cyc = 20'd0;
                    if (st_r.steps >= interval) begin
                        st_nxt.state = IRQOS_HOLD_IDLE;
                    end else begin
                        st_nxt.steps = st_r.steps + 8'd1;
                    end
                end else begin
                    st_nxt.cyc = st_r.cyc + 20'd1;
                end
                // a zero interval cancels the hold-off at once
                if (interval == `IRQOS_DEAS_RST) begin
                    st_nxt.state = IRQOS_HOLD_IDLE;
                end
            end
            default: begin
                st_nxt.state = IRQOS_HOLD_IDLE;
            end
        endcase
        if (soft_rst) begin
            st_nxt = '0;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign active = (st_r.state == IRQOS_HOLD_RUN);

endmodule // irqos_holdoff

// [rtl/irqos_top.sv]
// interrupt status collection and interrupt pin driver with apb registers
//
// What this block does
// - polarity bit 4 picks pin level
// - open-drain ignores polarity, always active low
// - clock select bit 1 puts crystal clock out
// - type bit 0: open-drain or push-pull, reset 0
// - type bit survives the soft digital reset
// - status bits show conditions regardless of enables
// - write one clears, write zero keeps
// - software event sets on enable going high
// - ready bit sets after reset, write one clears
// - bit 29 mirrors time-stamp unit pending
// - bit 28 mirrors switch fabric pending
// - bits 27, 26 mirror transceiver B, A
// - timer bit sets on wrap, write one clears
// - power bit clears only after control flags clear
// - power event skips the hold-off interval
// - bit 12 mirrors general-purpose I/O pending
// - output enable clear keeps pin de-asserted
// - master flag is any enabled active status
// - enable bit lets source drive the output
// - hold-off after de-assert, 10 us steps
`timescale 1ns/1ps
`include "irqos_defs.svh"

module irqos_top #(
    parameter int unsigned HOLDOFF_STEP_CYC = `IRQOS_DEAS_STEP_CYC,
    parameter int unsigned ADDR_W           = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // soft digital reset request, one cycle
    input  wire logic              soft_rst,
    // event sources
    input  wire logic              device_ready,
    input  wire logic              timestamp_unit_event,
    input  wire logic              fabric_event,
    input  wire logic              phy_b_event,
    input  wire logic              phy_a_event,
    input  wire logic              gpio_event,
    input  wire logic              timer_wrap_event,
    input  wire logic              power_event,
    input  wire logic              power_flags_pending,
    // crystal clock sample for debug output
    input  wire logic              xtal_clk,
    // interrupt pin
    output logic                   irq_out,
    output logic                   irq_oe
);
    import irqos_pkg::*;

    // register state of the block, apart from the hold-off sequencer in u_holdoff
    typedef struct packed {
        logic [7:0]  holdoff_interval;
        logic        holdoff_clr;
        logic        irq_en;
        logic        pin_polarity_sel;
        logic        clk_sel;
        logic        pin_type;
        logic [31:0] enable;
        logic        software_event;
        logic        ready;
        logic        timer_wrap;
        logic        power_event_flag;
        logic        ready_d;
        logic        line;
        logic        xtal_d;
        logic        irq_out;
        logic        irq_oe;
        logic [31:0] rdata;
        logic        pready;
        logic        pslverr;
    } irqos_state_t;

    irqos_state_t st_r;
    irqos_state_t st_nxt;

    logic        hold_active;
    logic [31:0] sts_view;
    logic [31:0] cfg_view;
    logic [31:0] pend;
    logic        irq_int;
    logic        line_gated;
    logic        wr_acc;
    logic        setup;
    irqos_sel_t  sel;

    // address decode, shared by read and write paths
    function automatic irqos_sel_t decode(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(`IRQOS_OFF_CFG)) begin
            return IRQOS_SEL_CFG;
        end else if (a == ADDR_W'(`IRQOS_OFF_STS)) begin
            return IRQOS_SEL_STS;
        end else if (a == ADDR_W'(`IRQOS_OFF_EN)) begin
            return IRQOS_SEL_EN;
        end
        return IRQOS_SEL_NONE;
    endfunction

    // write strobe expansion to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // hold-off interval timer
    irqos_holdoff #(
        .STEP_CYC (HOLDOFF_STEP_CYC)
    ) u_holdoff (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .soft_rst (soft_rst),
        .interval (st_r.holdoff_interval),
        .restart  (st_r.holdoff_clr),
        .line     (st_r.line),
        .active   (hold_active)
    );

    // live status view, sources shown whether enabled or not
    always_comb begin
        sts_view                   = 32'h0000_0000;
        sts_view[`IRQOS_B_SW]      = st_r.software_event;
        sts_view[`IRQOS_B_READY]   = st_r.ready;
        sts_view[`IRQOS_B_TSU]     = timestamp_unit_event;
        sts_view[`IRQOS_B_FABRIC]  = fabric_event;
        sts_view[`IRQOS_B_PHY_B]   = phy_b_event;
        sts_view[`IRQOS_B_PHY_A]   = phy_a_event;
        sts_view[`IRQOS_B_TIMER]   = st_r.timer_wrap;
        sts_view[`IRQOS_B_POWER]   = st_r.power_event_flag;
        sts_view[`IRQOS_B_GPIO]    = gpio_event;
    end

    // enabled sources and master flag
    assign pend       = sts_view & st_r.enable;
    assign irq_int    = |pend;
    // power event bypasses the hold-off, others wait it out
    assign line_gated = ((|(pend & ~(32'h0000_0001 << `IRQOS_B_POWER))) && !hold_active)
                        || pend[`IRQOS_B_POWER];

    // configuration view
    always_comb begin
        cfg_view = 32'h0000_0000;
        cfg_view[`IRQOS_CFG_DEAS_MSB:`IRQOS_CFG_DEAS_LSB] = st_r.holdoff_interval;
        cfg_view[`IRQOS_CFG_DEAS_STS] = hold_active;
        cfg_view[`IRQOS_CFG_IRQ_INT]  = irq_int;
        cfg_view[`IRQOS_CFG_IRQ_EN]   = st_r.irq_en;
        cfg_view[`IRQOS_CFG_POL]      = st_r.pin_polarity_sel;
        cfg_view[`IRQOS_CFG_CLK_SEL]  = st_r.clk_sel;
        cfg_view[`IRQOS_CFG_TYPE]     = st_r.pin_type;
    end

    // apb phases
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
    assign sel    = decode(paddr);

    // next state
    always_comb begin
        logic [31:0] wm;
        logic [31:0] wd;
        logic        sw_en_rise;
        wm         = lane_mask(pstrb);
        wd         = pwdata & wm;
        sw_en_rise = 1'b0;
        st_nxt     = st_r;

        // apb answer: one wait-free access cycle after setup
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup && (sel == IRQOS_SEL_NONE);
        st_nxt.rdata   = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (sel)
                IRQOS_SEL_CFG:  st_nxt.rdata = cfg_view;
                IRQOS_SEL_STS:  st_nxt.rdata = sts_view;
                IRQOS_SEL_EN:   st_nxt.rdata = st_r.enable;
                default:        st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // clear request is a single pulse
        st_nxt.holdoff_clr = 1'b0;

        // register writes
        if (wr_acc) begin
            case (sel)
                IRQOS_SEL_CFG: begin
                    if (pstrb[3]) begin
                        st_nxt.holdoff_interval = pwdata[`IRQOS_CFG_DEAS_MSB:`IRQOS_CFG_DEAS_LSB];
                    end
                    if (pstrb[1]) begin
                        st_nxt.holdoff_clr = pwdata[`IRQOS_CFG_DEAS_CLR];
                        st_nxt.irq_en      = pwdata[`IRQOS_CFG_IRQ_EN];
                    end
                    if (pstrb[0]) begin
                        st_nxt.pin_polarity_sel = pwdata[`IRQOS_CFG_POL];
                        st_nxt.clk_sel          = pwdata[`IRQOS_CFG_CLK_SEL];
                        st_nxt.pin_type         = pwdata[`IRQOS_CFG_TYPE];
                    end
                end
                IRQOS_SEL_STS: begin
                    // write one clears, zero leaves the bit alone
                    if (wd[`IRQOS_B_SW]) begin
                        st_nxt.software_event = 1'b0;
                    end
                    if (wd[`IRQOS_B_READY]) begin
                        st_nxt.ready = 1'b0;
                    end
                    if (wd[`IRQOS_B_TIMER]) begin
                        st_nxt.timer_wrap = 1'b0;
                    end
                    if (wd[`IRQOS_B_POWER] && !power_flags_pending) begin
                        st_nxt.power_event_flag = 1'b0;
                    end
                end
                IRQOS_SEL_EN: begin
                    sw_en_rise = wd[`IRQOS_B_SW] && !st_r.enable[`IRQOS_B_SW];
                    st_nxt.enable = ((st_r.enable & ~wm) | wd) & `IRQOS_STS_MASK;
                end
                default: begin
                    st_nxt.enable = st_r.enable;
                end
            endcase
        end

        // hardware sets, placed after clears so a same-cycle set wins
        if (sw_en_rise) begin
            st_nxt.software_event = 1'b1;
        end
        st_nxt.ready_d = device_ready;
        if (device_ready && !st_r.ready_d) begin
            st_nxt.ready = 1'b1;
        end
        if (timer_wrap_event) begin
            st_nxt.timer_wrap = 1'b1;
        end
        if (power_event) begin
            st_nxt.power_event_flag = 1'b1;
        end

        // internal line, not masked by output enable, status untouched
        st_nxt.line   = line_gated;
        st_nxt.xtal_d = xtal_clk;

        // pin driver
        if (st_r.clk_sel) begin
            // debug clock out, push-pull advised for a clean waveform
            st_nxt.irq_out = st_r.pin_type ? st_r.xtal_d : 1'b0;
            st_nxt.irq_oe  = st_r.pin_type ? 1'b1 : !st_r.xtal_d;
        end else if (st_r.pin_type) begin
            st_nxt.irq_out = st_r.pin_polarity_sel ? (st_r.irq_en && st_r.line)
                                                   : !(st_r.irq_en && st_r.line);
            st_nxt.irq_oe  = 1'b1;
        end else begin
            // open drain: pull low when asserted, polarity ignored
            st_nxt.irq_out = 1'b0;
            st_nxt.irq_oe  = st_r.irq_en && st_r.line;
        end

        // soft digital reset: all back to defaults but the pin type
        if (soft_rst) begin
            st_nxt                  = '0;
            st_nxt.holdoff_interval = `IRQOS_DEAS_RST;
            st_nxt.enable           = `IRQOS_EN_RST;
            st_nxt.pin_type         = st_r.pin_type;
            st_nxt.irq_out          = 1'b0;
            st_nxt.irq_oe           = 1'b0;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r                  <= '0;
            st_r.holdoff_interval <= `IRQOS_DEAS_RST;
            st_r.enable           <= `IRQOS_EN_RST;
            st_r.pin_type         <= `IRQOS_BIT_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign pready  = st_r.pready;
    assign prdata  = st_r.rdata;
    assign pslverr = st_r.pslverr;
    assign irq_out = st_r.irq_out;
    assign irq_oe  = st_r.irq_oe;

endmodule // irqos_top

// [dv/irqos_assertions.sv]
// port checks for the interrupt output block, bound into its top
`timescale 1ns/1ps
`include "irqos_defs.svh"

module irqos_assertions #(
    parameter int unsigned HOLDOFF_STEP_CYC = 4,
    parameter int unsigned ADDR_W           = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              soft_rst,
    input wire logic              timestamp_unit_event,
    input wire logic              fabric_event,
    input wire logic              phy_b_event,
    input wire logic              phy_a_event,
    input wire logic              gpio_event,
    input wire logic              xtal_clk,
    input wire logic              irq_out,
    input wire logic              irq_oe
);
    logic [15:0] cfg_r;
    logic [1:0]  quiet_r;
    logic [4:0]  live;
    logic        cfg_wr, rd_sts, rd_en, hole;

    // completed-access decode and live source vector
    assign cfg_wr = psel && penable && pready && pwrite && paddr == ADDR_W'(`IRQOS_OFF_CFG);
    assign rd_sts = pready && !pwrite && paddr == ADDR_W'(`IRQOS_OFF_STS);
    assign rd_en  = pready && !pwrite && paddr == ADDR_W'(`IRQOS_OFF_EN);
    assign hole   = pready && !(paddr inside {ADDR_W'(`IRQOS_OFF_CFG), ADDR_W'(`IRQOS_OFF_STS),
                                              ADDR_W'(`IRQOS_OFF_EN)});
    assign live   = {timestamp_unit_event, fabric_event, phy_b_event, phy_a_event, gpio_event};

    // shadow of low config bits, and cycles since they last changed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r   <= 16'h0000;
            quiet_r <= 2'h0;
        end else begin
            if (soft_rst)
                cfg_r <= cfg_r & 16'h0001;
            else if (cfg_wr)
                cfg_r <= {pstrb[1] ? pwdata[15:8] : cfg_r[15:8], pstrb[0] ? pwdata[7:0] : cfg_r[7:0]};
            quiet_r <= (soft_rst || cfg_wr) ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
        end
    end

    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // register answers, then pin behaviour once config has settled
    property p_hole; hole |-> pslverr && prdata == 32'h0000_0000; endproperty
    a_hole: assert property (p_hole) else $error("unmapped access not refused");
    property p_rsvd; rd_sts || rd_en |-> (prdata & ~`IRQOS_STS_MASK) == 32'h0000_0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_live; $stable(live) [*4] ##0 rd_sts |-> {prdata[29:26], prdata[12]} == live; endproperty
    a_live: assert property (p_live) else $error("source mirror bits wrong");
    property p_od_low; quiet_r == 2'h3 && !cfg_r[0] && !cfg_r[1] |-> !irq_out; endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain pin data high");
    property p_off; quiet_r == 2'h3 && !cfg_r[8] && !cfg_r[1] |-> irq_oe == cfg_r[0] && irq_out == (cfg_r[0] && !cfg_r[4]); endproperty
    a_off: assert property (p_off) else $error("disabled pin not idle");
    property p_pp; quiet_r == 2'h3 && cfg_r[0] && !cfg_r[1] |-> irq_oe; endproperty
    a_pp: assert property (p_pp) else $error("push-pull pin not driven");
    property p_clk; quiet_r == 2'h3 && cfg_r[1] |-> (cfg_r[0] ? irq_out == $past(xtal_clk, 2) : irq_oe == !$past(xtal_clk, 2)); endproperty
    a_clk: assert property (p_clk) else $error("clock not on pin");
    property p_rst; $rose(presetn) |-> !pready && !irq_oe && !irq_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // irqos_assertions

bind irqos_top irqos_assertions #(.HOLDOFF_STEP_CYC(HOLDOFF_STEP_CYC), .ADDR_W(ADDR_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .soft_rst(soft_rst), .timestamp_unit_event(timestamp_unit_event), .fabric_event(fabric_event),
    .phy_b_event(phy_b_event), .phy_a_event(phy_a_event), .gpio_event(gpio_event),
    .xtal_clk(xtal_clk), .irq_out(irq_out), .irq_oe(irq_oe)
);

// [dv/irqos_host_model.sv]
// host side of the interrupt pin: board pull-up and level decode
`timescale 1ns/1ps

module irqos_host_model (
    input  wire logic irq_out,
    input  wire logic irq_oe,
    input  wire logic push_pull,
    input  wire logic active_high,
    output logic      pin_level,
    output logic      irq_seen
);
    // released open-drain line floats up to the wired-or pull-up
    assign pin_level = irq_oe ? irq_out : 1'b1;
    // host decodes assertion from the pin setup it programmed
    assign irq_seen = push_pull ? (pin_level == active_high) : !pin_level;
endmodule // irqos_host_model

// [dv/irq_output_and_status_tb.sv]
// self-checking bench for the interrupt output block
`timescale 1ns/1ps
`include "irqos_defs.svh"

module irq_output_and_status_tb;
    logic        pclk, presetn, ce, psel, penable, pwrite, soft_rst, xtal_clk, pserr;
    logic        dev_rdy, tsu_ev, fab_ev, phyb_ev, phya_ev, gpio_ev, tmr_ev, pwr_ev, pwr_pend;
    logic        pready, pslverr, irq_out, irq_oe, pin_level, irq_seen;
    logic [11:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rdata, rnd, cfg_m;
    integer      num_errors, samples_checked, seed;

    // 200 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // crystal stand-in, toggles every bus cycle
    always @(posedge pclk) xtal_clk <= presetn ? ~xtal_clk : 1'b0;

    irqos_top #(.HOLDOFF_STEP_CYC(4), .ADDR_W(12)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .soft_rst(soft_rst), .device_ready(dev_rdy), .timestamp_unit_event(tsu_ev), .fabric_event(fab_ev),
        .phy_b_event(phyb_ev), .phy_a_event(phya_ev), .gpio_event(gpio_ev), .timer_wrap_event(tmr_ev),
        .power_event(pwr_ev), .power_flags_pending(pwr_pend), .xtal_clk(xtal_clk), .irq_out(irq_out),
        .irq_oe(irq_oe)
    );

    irqos_host_model host_u (
        .irq_out(irq_out), .irq_oe(irq_oe), .push_pull(cfg_m[0]), .active_high(cfg_m[4]),
        .pin_level(pin_level), .irq_seen(irq_seen)
    );

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdata = prdata;
        pserr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rdata, exp);
    endtask

    // config write, mirrored into the host's view of the pin
    task automatic wcfg(input logic [31:0] v);
        cfg_m = v;
        apb(1'b1, `IRQOS_OFF_CFG, v);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, soft_rst, dev_rdy, tmr_ev, pwr_ev, pwr_pend} = '0;
        {tsu_ev, fab_ev, phyb_ev, phya_ev, gpio_ev, paddr, pwdata, cfg_m} = '0;
        {num_errors, samples_checked} = '0;
        ce = 1'b1;
        pstrb = 4'hF;
        seed = 55380;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped hole, reserved enable bits
        rdc("cfg rst", `IRQOS_OFF_CFG, 32'h0000_0000);
        rdc("sts rst", `IRQOS_OFF_STS, 32'h0000_0000);
        rdc("hole", 12'h060, 32'h0000_0000);
        check("hole err", pserr, 32'h0000_0001);
        apb(1'b1, `IRQOS_OFF_EN, 32'hFFFF_FFFF);
        rdc("en mask", `IRQOS_OFF_EN, `IRQOS_STS_MASK);
        apb(1'b1, `IRQOS_OFF_EN, 32'h0000_0000);
        // latched events, write zero keeps, write one clears
        dev_rdy <= 1'b1;
        @(posedge pclk) tmr_ev <= 1'b1;
        pwr_ev <= 1'b1;
        pwr_pend <= 1'b1;
        @(posedge pclk) tmr_ev <= 1'b0;
        pwr_ev <= 1'b0;
        rdc("sts set", `IRQOS_OFF_STS, 32'hC00A_0000);
        apb(1'b1, `IRQOS_OFF_STS, 32'h0000_0000);
        rdc("w0 keeps", `IRQOS_OFF_STS, 32'hC00A_0000);
        apb(1'b1, `IRQOS_OFF_STS, 32'hFFFF_FFFF);
        rdc("pend blocks", `IRQOS_OFF_STS, 32'h0002_0000);
        pwr_pend <= 1'b0;
        apb(1'b1, `IRQOS_OFF_STS, 32'h0002_0000);
        rdc("pwr clr", `IRQOS_OFF_STS, 32'h0000_0000);
        // clock enable low: an event pulse is not taken
        ce <= 1'b0;
        tmr_ev <= 1'b1;
        @(posedge pclk) tmr_ev <= 1'b0;
        @(posedge pclk) ce <= 1'b1;
        rdc("frozen", `IRQOS_OFF_STS, 32'h0000_0000);
        // mirrored sources follow random levels
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            {tsu_ev, fab_ev, phyb_ev, phya_ev, gpio_ev} <= rnd[4:0];
            repeat (3) @(posedge pclk);
            rdc("live", `IRQOS_OFF_STS, {2'b00, rnd[4:1], 13'h0000, rnd[0], 12'h000});
        end
        {tsu_ev, fab_ev, phyb_ev, phya_ev, gpio_ev} <= 5'h00;
        // pin: push-pull active high, then low, then open-drain, then off
        apb(1'b1, `IRQOS_OFF_EN, 32'h000A_0000);
        wcfg(32'h0400_0111);
        @(posedge pclk) tmr_ev <= 1'b1;
        @(posedge pclk) tmr_ev <= 1'b0;
        repeat (4) @(posedge pclk);
        check("pin high", pin_level, 32'h0000_0001);
        rdc("master", `IRQOS_OFF_CFG, 32'h0400_1111);
        wcfg(32'h0400_0101);
        repeat (4) @(posedge pclk);
        check("pin low", pin_level, 32'h0000_0000);
        wcfg(32'h0400_0110);
        repeat (4) @(posedge pclk);
        check("od drive", {pin_level, irq_oe}, 32'h0000_0001);
        wcfg(32'h0400_0011);
        repeat (4) @(posedge pclk);
        check("off", irq_seen, 32'h0000_0000);
        rdc("sts kept", `IRQOS_OFF_STS, 32'h0008_0000);
        // hold-off after a clear, and the power event that skips it
        wcfg(32'h0400_0111);
        repeat (4) @(posedge pclk);
        check("on", irq_seen, 32'h0000_0001);
        apb(1'b1, `IRQOS_OFF_STS, 32'h0008_0000);
        @(posedge pclk) tmr_ev <= 1'b1;
        @(posedge pclk) tmr_ev <= 1'b0;
        repeat (3) @(posedge pclk);
        check("held", irq_seen, 32'h0000_0000);
        rdc("hold sts", `IRQOS_OFF_CFG, 32'h0400_3111);
        repeat (30) @(posedge pclk);
        check("released", irq_seen, 32'h0000_0001);
        apb(1'b1, `IRQOS_OFF_STS, 32'h0008_0000);
        @(posedge pclk) pwr_ev <= 1'b1;
        @(posedge pclk) pwr_ev <= 1'b0;
        repeat (4) @(posedge pclk);
        check("bypass", irq_seen, 32'h0000_0001);
        // clock out with push-pull, then soft and hard reset
        wcfg(32'h0000_0113);
        repeat (8) @(posedge pclk);
        @(posedge pclk) soft_rst <= 1'b1;
        @(posedge pclk) soft_rst <= 1'b0;
        rdc("soft", `IRQOS_OFF_CFG, 32'h0000_0001);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("hard", `IRQOS_OFF_CFG, 32'h0000_0000);
        complete_run();
    end
endmodule // irq_output_and_status_tb
